// ---- hdl/psc_regs.sv ----
// PHY management registers 18..28: address, error counters, LEDs, crossover.
// Assumes the management controller and event sources share clk.
`timescale 1ns/100ps
`default_nettype none
module psc_regs #(
  parameter int unsigned SLOT_MIN_CYC = psc_pkg::SLOT_MIN_CYC,
  parameter int unsigned SLOT_MAX_CYC = psc_pkg::SLOT_MAX_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Management register port
  input  wire logic [4:0]  mgmt_addr,
  input  wire logic        mgmt_rd,
  input  wire logic        mgmt_wr,
  input  wire logic [15:0] mgmt_wdata,
  output var  logic [15:0] mgmt_rdata_q,
  output var  logic        mgmt_rvalid_q,
  // Receive and transmit events from the PHY datapath
  input  wire logic        false_carrier_evt,
  input  wire logic        disconnect_evt,
  input  wire logic        rx_frame_active,
  input  wire logic        rx_frame_end,
  input  wire logic        rx_sym_valid,
  input  wire logic        rx_sym_bad,
  input  wire logic        premature_end_evt,
  input  wire logic        eof_err_evt,
  input  wire logic        jabber_evt,
  // Link indications
  input  wire logic        link_up,
  input  wire logic        activity,
  input  wire logic        speed_100,
  input  wire logic        collision,
  // Outputs
  output var  logic        activity_led_out_b_q,
  output var  logic        link_led_out_b_q,
  output var  logic        pair_crossover_q,
  output var  logic [15:0] equalizer_ctrl_q
);

  localparam int unsigned NC = psc_pkg::NUM_COUNTERS;

  logic [15:0]   cnt_q [NC];
  logic [NC-1:0] evt;
  logic [NC-1:0] cnt_rd;
  logic [15:0]   led_sel_q;
  logic [7:0]    xo_high_q;
  logic          xo_auto_q;
  logic          xo_manual_q;
  logic [3:0]    xo_timer_q;
  logic          xo_complete;
  logic [2:0]    sym_run_q;
  logic          frame_err_q;
  logic          sym_err;
  logic          sym_count;
  logic          frame_bad;
  logic          act_d;
  logic          link_d;
  logic [15:0]   rdata_d;

  // Saturating increment shared by all counters
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == psc_pkg::CNT_MAX) ? v : v + 16'h0001;
  endfunction : sat_inc

  function automatic logic is_counter(input logic [4:0] a);
    is_counter = (a >= psc_pkg::ADDR_FALSE_CARRIER) &&
                 (a <= psc_pkg::ADDR_JABBER);
  endfunction : is_counter

  // Symbol error grouping: the first bad symbol of a run counts, the next
  // five do not; a good symbol or frame end restarts the group.
  assign sym_err   = rx_sym_valid && rx_sym_bad;
  assign sym_count = sym_err && (sym_run_q == 3'h0);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sym_run_q <= 3'h0;
    end else if (rx_frame_end || !rx_frame_active) begin
      sym_run_q <= 3'h0;
    end else if (rx_sym_valid && !rx_sym_bad) begin
      sym_run_q <= 3'h0;
    end else if (sym_err) begin
      if (sym_run_q == psc_pkg::SYMBOL_GROUP - 3'h1) begin
        sym_run_q <= 3'h0;
      end else begin
        sym_run_q <= sym_run_q + 3'h1;
      end
    end
  end

  // Errors seen during a frame are folded into one event at its end
  assign frame_bad = frame_err_q || sym_err || premature_end_evt;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_err_q <= 1'b0;
    end else if (rx_frame_end) begin
      frame_err_q <= 1'b0;
    end else if (rx_frame_active && (sym_err || premature_end_evt)) begin
      frame_err_q <= 1'b1;
    end
  end

  always_comb begin
    evt = '0;
    evt[psc_pkg::CNT_FALSE_CARRIER] = false_carrier_evt;
    evt[psc_pkg::CNT_DISCONNECT]    = disconnect_evt;
    evt[psc_pkg::CNT_ERROR_FRAME]   = rx_frame_end && frame_bad;
    evt[psc_pkg::CNT_SYMBOL_ERROR]  = sym_count;
    evt[psc_pkg::CNT_PREMATURE_END] = premature_end_evt;
    evt[psc_pkg::CNT_EOF_ERROR]     = eof_err_evt;
    evt[psc_pkg::CNT_JABBER]        = jabber_evt;
  end

  always_comb begin
    cnt_rd = '0;
    if (mgmt_rd && is_counter(mgmt_addr)) begin
      cnt_rd[3'(mgmt_addr - psc_pkg::ADDR_FALSE_CARRIER)] = 1'b1;
    end
  end

  // A read clears the counter, but an event in the same cycle survives
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NC; i++) begin
        cnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NC; i++) begin
        if (cnt_rd[i]) begin
          cnt_q[i] <= {15'h0000, evt[i]};
        end else if (evt[i]) begin
          cnt_q[i] <= sat_inc(cnt_q[i]);
        end
      end
    end
  end

  // Writable registers; counter and address registers ignore writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      equalizer_ctrl_q <= psc_pkg::EQUALIZER_RESET;
    end else if (mgmt_wr && mgmt_addr == psc_pkg::ADDR_EQUALIZER) begin
      equalizer_ctrl_q <= mgmt_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      led_sel_q <= psc_pkg::LED_SELECT_RESET;
    end else if (mgmt_wr && mgmt_addr == psc_pkg::ADDR_LED_SELECT) begin
      led_sel_q <= mgmt_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      xo_high_q   <= psc_pkg::XOVER_HIGH_RESET;
      xo_auto_q   <= 1'b0;
      xo_manual_q <= 1'b0;
      xo_timer_q  <= psc_pkg::RES_TIMER_RESET;
    end else if (mgmt_wr && mgmt_addr == psc_pkg::ADDR_CROSSOVER) begin
      xo_high_q   <= mgmt_wdata[15:psc_pkg::XO_HIGH_LSB];
      xo_auto_q   <= mgmt_wdata[psc_pkg::XO_AUTO_EN_BIT];
      xo_manual_q <= mgmt_wdata[psc_pkg::XO_MANUAL_BIT];
      xo_timer_q  <= mgmt_wdata[psc_pkg::XO_TIMER_MSB:0];
    end
  end

  psc_xover #(
    .SLOT_MIN_CYC (SLOT_MIN_CYC),
    .SLOT_MAX_CYC (SLOT_MAX_CYC)
  ) u_xover (
    .clk          (clk),
    .rst_b        (rst_b),
    .auto_en      (xo_auto_q),
    .manual_xover (xo_manual_q),
    .timer_code   (xo_timer_q),
    .link_up      (link_up),
    .crossover_q  (pair_crossover_q),
    .complete_q   (xo_complete)
  );

  // LED routing; indications are active high, the pins active low
  always_comb begin
    case (psc_pkg::psc_led_mode_e'(led_sel_q[2:0]))
      psc_pkg::PSC_LED_ACT_LINK: begin
        act_d  = activity;
        link_d = link_up;
      end
      psc_pkg::PSC_LED_SPD_COL: begin
        act_d  = speed_100;
        link_d = collision;
      end
      psc_pkg::PSC_LED_SPD_LINK: begin
        act_d  = speed_100;
        link_d = link_up;
      end
      psc_pkg::PSC_LED_ACT_COL: begin
        act_d  = activity;
        link_d = collision;
      end
      psc_pkg::PSC_LED_OFF_OFF: begin
        act_d  = 1'b0;
        link_d = 1'b0;
      end
      psc_pkg::PSC_LED_OFF_ON: begin
        act_d  = 1'b0;
        link_d = 1'b1;
      end
      psc_pkg::PSC_LED_ON_OFF: begin
        act_d  = 1'b1;
        link_d = 1'b0;
      end
      psc_pkg::PSC_LED_ON_ON: begin
        act_d  = 1'b1;
        link_d = 1'b1;
      end
      default: begin
        act_d  = 1'b0;
        link_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      activity_led_out_b_q <= 1'b1;
      link_led_out_b_q     <= 1'b1;
    end else begin
      activity_led_out_b_q <= ~act_d;
      link_led_out_b_q     <= ~link_d;
    end
  end

  // Read mux; addresses outside 18..28 belong elsewhere and read zero
  always_comb begin
    rdata_d = 16'h0000;
    if (is_counter(mgmt_addr)) begin
      rdata_d = cnt_q[3'(mgmt_addr - psc_pkg::ADDR_FALSE_CARRIER)];
    end else begin
      case (mgmt_addr)
        psc_pkg::ADDR_PHY_ADDRESS: rdata_d = psc_pkg::PHY_ADDRESS_VALUE;
        psc_pkg::ADDR_EQUALIZER:   rdata_d = equalizer_ctrl_q;
        psc_pkg::ADDR_LED_SELECT:  rdata_d = led_sel_q;
        psc_pkg::ADDR_CROSSOVER: begin
          rdata_d = {xo_high_q, xo_auto_q, xo_manual_q,
                     pair_crossover_q, xo_complete, xo_timer_q};
        end
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mgmt_rdata_q  <= 16'h0000;
      mgmt_rvalid_q <= 1'b0;
    end else begin
      mgmt_rvalid_q <= mgmt_rd;
      if (mgmt_rd) begin
        mgmt_rdata_q <= rdata_d;
      end
    end
  end

endmodule : psc_regs
`default_nettype wire

// ---- hdl/psc_pkg.sv ----
// Constants for the PHY status, error counter and crossover register bank.
// Assumes a 40 MHz device clock and a 5-bit management register address.
package psc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 25;

  // Management register addresses
  localparam logic [4:0] ADDR_PHY_ADDRESS   = 5'h12;
  localparam logic [4:0] ADDR_FALSE_CARRIER = 5'h13;
  localparam logic [4:0] ADDR_DISCONNECT    = 5'h14;
  localparam logic [4:0] ADDR_ERROR_FRAME   = 5'h15;
  localparam logic [4:0] ADDR_SYMBOL_ERROR  = 5'h16;
  localparam logic [4:0] ADDR_PREMATURE_END = 5'h17;
  localparam logic [4:0] ADDR_EOF_ERROR     = 5'h18;
  localparam logic [4:0] ADDR_JABBER        = 5'h19;
  localparam logic [4:0] ADDR_EQUALIZER     = 5'h1a;
  localparam logic [4:0] ADDR_LED_SELECT    = 5'h1b;
  localparam logic [4:0] ADDR_CROSSOVER     = 5'h1c;

  // Counter bank: index i lives at ADDR_FALSE_CARRIER + i
  localparam int unsigned NUM_COUNTERS = 7;
  localparam int unsigned CNT_FALSE_CARRIER = 0;
  localparam int unsigned CNT_DISCONNECT    = 1;
  localparam int unsigned CNT_ERROR_FRAME   = 2;
  localparam int unsigned CNT_SYMBOL_ERROR  = 3;
  localparam int unsigned CNT_PREMATURE_END = 4;
  localparam int unsigned CNT_EOF_ERROR     = 5;
  localparam int unsigned CNT_JABBER        = 6;
  localparam logic [15:0] CNT_MAX           = 16'hffff;

  // Fixed PHY address value
  localparam logic [15:0] PHY_ADDRESS_VALUE = 16'h0001;

  // Reset values
  localparam logic [15:0] EQUALIZER_RESET   = 16'h0000;
  localparam logic [15:0] LED_SELECT_RESET  = 16'h0000;
  localparam logic [7:0]  XOVER_HIGH_RESET  = 8'h00;
  localparam logic [3:0]  RES_TIMER_RESET   = 4'h0;

  // Crossover control field positions
  localparam int unsigned XO_AUTO_EN_BIT  = 7;
  localparam int unsigned XO_MANUAL_BIT   = 6;
  localparam int unsigned XO_STATUS_BIT   = 5;
  localparam int unsigned XO_COMPLETE_BIT = 4;
  localparam int unsigned XO_TIMER_MSB    = 3;
  localparam int unsigned XO_HIGH_LSB     = 8;

  // Symbol errors per counted group
  localparam logic [2:0] SYMBOL_GROUP = 3'h6;

  // Resolution slot time, 80 ms at code 0 up to 105 ms at code 15
  localparam int unsigned SLOT_MIN_NS  = 80_000_000;
  localparam int unsigned SLOT_MAX_NS  = 105_000_000;
  localparam int unsigned SLOT_MIN_CYC = SLOT_MIN_NS / CLK_PERIOD_NS;
  localparam int unsigned SLOT_MAX_CYC = SLOT_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned TIMER_CODES  = 15;
  localparam int unsigned SLOT_CNT_W   = 24;

  typedef enum logic [2:0] {
    PSC_LED_ACT_LINK  = 3'b000,
    PSC_LED_SPD_COL   = 3'b001,
    PSC_LED_SPD_LINK  = 3'b010,
    PSC_LED_ACT_COL   = 3'b011,
    PSC_LED_OFF_OFF   = 3'b100,
    PSC_LED_OFF_ON    = 3'b101,
    PSC_LED_ON_OFF    = 3'b110,
    PSC_LED_ON_ON     = 3'b111
  } psc_led_mode_e;

  typedef enum logic [1:0] {
    PSC_XO_MANUAL  = 2'b00,
    PSC_XO_SEARCH  = 2'b01,
    PSC_XO_LOCKED  = 2'b10
  } psc_xo_state_e;

endpackage : psc_pkg

// ---- hdl/psc_xover.sv ----
// Automatic MDI/MDI-X crossover resolver.
// Assumes link_up comes from PHY logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module psc_xover #(
  parameter int unsigned SLOT_MIN_CYC = psc_pkg::SLOT_MIN_CYC,
  parameter int unsigned SLOT_MAX_CYC = psc_pkg::SLOT_MAX_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       auto_en,
  input  wire logic       manual_xover,
  input  wire logic [3:0] timer_code,
  input  wire logic       link_up,
  output var  logic       crossover_q,
  output var  logic       complete_q
);

  localparam int unsigned W = psc_pkg::SLOT_CNT_W;

  psc_pkg::psc_xo_state_e state_q;
  logic [W-1:0]           slot_cnt_q;
  logic [W-1:0]           slot_last;

  // Linear between the two end codes; the divide is constant per code
  function automatic logic [W-1:0] slot_len(input logic [3:0] code);
    int unsigned span;
    span = (SLOT_MAX_CYC - SLOT_MIN_CYC) * code;
    slot_len = W'(SLOT_MIN_CYC + span / psc_pkg::TIMER_CODES);
  endfunction : slot_len

  assign slot_last = slot_len(timer_code) - W'(1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= psc_pkg::PSC_XO_MANUAL;
    end else if (!auto_en) begin
      state_q <= psc_pkg::PSC_XO_MANUAL;
    end else if (link_up) begin
      state_q <= psc_pkg::PSC_XO_LOCKED;
    end else begin
      state_q <= psc_pkg::PSC_XO_SEARCH;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slot_cnt_q <= '0;
    end else if (state_q != psc_pkg::PSC_XO_SEARCH || slot_cnt_q >= slot_last) begin
      slot_cnt_q <= '0;
    end else begin
      slot_cnt_q <= slot_cnt_q + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      crossover_q <= 1'b0;
      complete_q  <= 1'b1;
    end else begin
      case (state_q)
        psc_pkg::PSC_XO_MANUAL: begin
          crossover_q <= manual_xover;
          complete_q  <= 1'b1;
        end
        psc_pkg::PSC_XO_SEARCH: begin
          // Hop only after a full slot so the partner can settle
          if (slot_cnt_q >= slot_last) begin
            crossover_q <= ~crossover_q;
          end
          complete_q <= 1'b0;
        end
        psc_pkg::PSC_XO_LOCKED: begin
          complete_q <= 1'b1;
        end
        default: begin
          complete_q <= 1'b1;
        end
      endcase
    end
  end

endmodule : psc_xover
`default_nettype wire

// ---- verif/psc_regs_props.sv ----
// Port checker for the PHY register bank, bound to psc_regs.
// Assumes one clock domain and the one-cycle read answer.
`timescale 1ns/100ps
`default_nettype none
module psc_regs_props #(
  parameter int unsigned SLOT_MIN_CYC = psc_pkg::SLOT_MIN_CYC,
  parameter int unsigned SLOT_MAX_CYC = psc_pkg::SLOT_MAX_CYC
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [4:0]  mgmt_addr,
  input wire logic        mgmt_rd,
  input wire logic        mgmt_wr,
  input wire logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata_q,
  input wire logic        mgmt_rvalid_q,
  input wire logic        false_carrier_evt,
  input wire logic        link_up,
  input wire logic        activity,
  input wire logic        speed_100,
  input wire logic        collision,
  input wire logic        activity_led_out_b_q,
  input wire logic        link_led_out_b_q,
  input wire logic        pair_crossover_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic        pair_prev_q;
  logic [23:0] since_q;
  logic [2:0]  xwr_q;
  logic        fc_rd;
  assign fc_rd = mgmt_rd && mgmt_addr == psc_pkg::ADDR_FALSE_CARRIER;
  // Recent crossover writes excuse a manual change of the pair
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pair_prev_q <= 1'b0;
      since_q     <= 24'h00_0000;
      xwr_q       <= 3'h0;
    end else begin
      pair_prev_q <= pair_crossover_q;
      since_q     <= (pair_crossover_q != pair_prev_q) ? 24'h00_0001
                                                      : since_q + 24'h00_0001;
      xwr_q <= {xwr_q[1:0], mgmt_wr && mgmt_addr == psc_pkg::ADDR_CROSSOVER};
    end
  end
  sequence s_led_quiet;
    !mgmt_wr && $stable({activity, link_up, speed_100, collision});
  endsequence
  a_read_answer: assert property (mgmt_rd |=> mgmt_rvalid_q)
    else $error("Read strobe not answered");
  a_no_stray_valid: assert property (!mgmt_rd |=> !mgmt_rvalid_q)
    else $error("Read valid without strobe");
  a_phy_addr_const: assert property (
    mgmt_rd && mgmt_addr == psc_pkg::ADDR_PHY_ADDRESS
    |=> mgmt_rdata_q == psc_pkg::PHY_ADDRESS_VALUE)
    else $error("PHY address read wrong");
  a_offmap_zero: assert property (
    mgmt_rd && (mgmt_addr < 5'h12 || mgmt_addr > 5'h1c)
    |=> mgmt_rdata_q == 16'h0000)
    else $error("Unmapped read not zero");
  a_read_clears: assert property (
    (fc_rd && !false_carrier_evt) ##1 fc_rd |=> mgmt_rdata_q == 16'h0000)
    else $error("Counter not cleared by read");
  a_rdata_hold: assert property (!mgmt_rd |=> $stable(mgmt_rdata_q))
    else $error("Read data moved without read");
  a_led_steady: assert property (s_led_quiet [*2] |=>
    $stable({activity_led_out_b_q, link_led_out_b_q}))
    else $error("LED changed without cause");
  a_pair_frozen: assert property (
    (link_up && !mgmt_wr) [*3] |=> $stable(pair_crossover_q))
    else $error("Pair moved with link up");
  a_slot_min: assert property (
    $changed(pair_crossover_q) && xwr_q == 3'h0 |-> since_q >= SLOT_MIN_CYC)
    else $error("Pair toggled before slot time");
  c_read_clear: cover property (fc_rd ##1 fc_rd);
  c_pair_toggle: cover property ($changed(pair_crossover_q) && xwr_q == 3'h0);
  c_led_forced: cover property (
    mgmt_wr && mgmt_addr == psc_pkg::ADDR_LED_SELECT && mgmt_wdata[2]);
endmodule : psc_regs_props
bind psc_regs psc_regs_props #(.SLOT_MIN_CYC(SLOT_MIN_CYC),
  .SLOT_MAX_CYC(SLOT_MAX_CYC)) psc_regs_props_i (.clk(clk), .rst_b(rst_b),
  .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr),
  .mgmt_wdata(mgmt_wdata),
  .mgmt_rdata_q(mgmt_rdata_q), .mgmt_rvalid_q(mgmt_rvalid_q),
  .false_carrier_evt(false_carrier_evt), .link_up(link_up),
  .activity(activity), .speed_100(speed_100), .collision(collision),
  .activity_led_out_b_q(activity_led_out_b_q),
  .link_led_out_b_q(link_led_out_b_q), .pair_crossover_q(pair_crossover_q));
`default_nettype wire

// ---- verif/psc_mac_model.sv ----
// Management controller model driving the register port of the bank.
// Assumes one strobe per access and the answer one cycle after it.
`timescale 1ns/100ps
`default_nettype none
module psc_mac_model (
  input  wire logic        clk,
  input  wire logic [15:0] mgmt_rdata_q,
  input  wire logic        mgmt_rvalid_q,
  output var  logic [4:0]  mgmt_addr,
  output var  logic        mgmt_rd,
  output var  logic        mgmt_wr,
  output var  logic [15:0] mgmt_wdata
);
  initial begin
    mgmt_addr  = 5'h00;
    mgmt_rd    = 1'b0;
    mgmt_wr    = 1'b0;
    mgmt_wdata = 16'h0000;
  end
  // Released lines show the inverse so a stale value cannot pass
  task automatic rd(input logic [4:0] a, input int n,
                    output logic [15:0] d0, output logic [15:0] d1);
    @(posedge clk);
    mgmt_addr <= a;
    mgmt_rd   <= 1'b1;
    repeat (n) @(posedge clk);
    mgmt_rd   <= 1'b0;
    mgmt_addr <= ~a;
    if (n == 2) d0 = mgmt_rdata_q;
    @(posedge clk);
    if (n == 2) d1 = mgmt_rdata_q;
    else d0 = mgmt_rdata_q;
  endtask : rd
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    mgmt_addr  <= a;
    mgmt_wdata <= d;
    mgmt_wr    <= 1'b1;
    @(posedge clk);
    mgmt_wr    <= 1'b0;
    mgmt_addr  <= ~a;
    mgmt_wdata <= ~d;
  endtask : wr
endmodule : psc_mac_model
`default_nettype wire

// ---- verif/psc_regs_tb_top.sv ----
// Self-checking bench for the PHY status, counter and crossover bank.
// Assumes the checker bind and the management model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module psc_regs_tb_top;
  localparam int unsigned MIN_C = 20;
  localparam int unsigned MAX_C = 35;
  logic        clk;
  logic        rst_b;
  logic [4:0]  mgmt_addr;
  logic        mgmt_rd;
  logic        mgmt_wr;
  logic [15:0] mgmt_wdata;
  logic [15:0] mgmt_rdata_q;
  logic        mgmt_rvalid_q;
  logic [4:0]  ev;
  logic [3:0]  fr;
  logic [3:0]  ln;
  logic        act_b;
  logic        lnk_b;
  logic        pair;
  logic [15:0] eq;
  int          n_fail = 0;
  int          checked = 0;
  int          cyc = 0;
  psc_mac_model psc_mac_model_i (.clk(clk), .mgmt_rdata_q(mgmt_rdata_q),
    .mgmt_rvalid_q(mgmt_rvalid_q), .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd),
    .mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata));
  psc_regs #(.SLOT_MIN_CYC(MIN_C), .SLOT_MAX_CYC(MAX_C)) psc_regs_i (
    .clk(clk), .rst_b(rst_b), .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd),
    .mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata), .mgmt_rdata_q(mgmt_rdata_q),
    .mgmt_rvalid_q(mgmt_rvalid_q), .false_carrier_evt(ev[0]),
    .disconnect_evt(ev[1]), .rx_frame_active(fr[3]), .rx_frame_end(fr[2]),
    .rx_sym_valid(fr[1]), .rx_sym_bad(fr[0]), .premature_end_evt(ev[2]),
    .eof_err_evt(ev[3]), .jabber_evt(ev[4]), .activity(ln[3]),
    .link_up(ln[2]), .speed_100(ln[1]), .collision(ln[0]),
    .activity_led_out_b_q(act_b), .link_led_out_b_q(lnk_b),
    .pair_crossover_q(pair), .equalizer_ctrl_q(eq));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [1:0] led_exp(input logic [2:0] c,
                                         input logic [3:0] s);
    case (c)
      3'h0: return ~{s[3], s[2]};
      3'h1: return ~{s[1], s[0]};
      3'h2: return ~{s[1], s[2]};
      3'h3: return ~{s[3], s[0]};
      default: return ~c[1:0];
    endcase
  endfunction : led_exp
  // Forced codes 4..7 carry the on/off pattern in their low two bits
  function automatic logic [15:0] sym_exp(input int r);
    return 16'((r + 5) / 6);
  endfunction : sym_exp
  function automatic int slot_exp(input logic [3:0] c);
    return MIN_C + (MAX_C - MIN_C) * c / 15;
  endfunction : slot_exp
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d0;
    logic [15:0] d1;
    psc_mac_model_i.rd(a, 1, d0, d1);
    check(d0, e);
  endtask : rd_chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    psc_mac_model_i.wr(a, d);
  endtask : wr
  task automatic hold(input int i, input int n);
    @(posedge clk);
    ev <= 5'(1 << i);
    repeat (n) @(posedge clk);
    ev <= 5'h00;
  endtask : hold
  task automatic frame(input int r, input logic prem);
    @(posedge clk);
    fr <= {3'b101, r > 0};
    repeat (r > 0 ? r : 1) @(posedge clk);
    fr <= 4'b1010;
    @(posedge clk);
    fr <= 4'b1000;
    ev[2] <= prem;
    @(posedge clk);
    fr <= 4'b1100;
    ev[2] <= 1'b0;
    @(posedge clk);
    fr <= 4'b0000;
  endtask : frame
  task automatic flip(output int n);
    logic p;
    p = pair;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pair === p && n < 200);
  endtask : flip
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    logic [15:0] d0, d1, r;
    logic [3:0]  c4;
    logic [4:0]  ca [5];
    int          rs [5];
    int          n, t;
    rst_b = 1'b0;
    ev = 5'h00;
    fr = 4'h0;
    ln = 4'h0;
    void'($urandom(38074));
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 18; a <= 28; a++) begin
      r = a == 18 ? 16'h0001 : a == 28 ? 16'h0010 : 16'h0000;
      rd_chk(5'(a), r);
    end
    check({14'h0000, act_b, lnk_b}, 16'h0003);
    wr(5'h12, 16'hffff);
    wr(5'h19, 16'h1234);
    rd_chk(5'h12, 16'h0001);
    rd_chk(5'h19, 16'h0000);
    rd_chk(5'h05, 16'h0000);
    rd_chk(5'h1f, 16'h0000);
    r = 16'($urandom);
    wr(5'h1a, r);
    rd_chk(5'h1a, r);
    check(eq, r);
    ca = '{5'h13, 5'h14, 5'h17, 5'h18, 5'h19};
    for (int i = 0; i < 5; i++) begin
      n = $urandom_range(9, 1);
      hold(i, n);
      psc_mac_model_i.rd(ca[i], 2, d0, d1);
      check(d0, 16'(n));
      check(d1, 16'h0000);
    end
    hold(4, 65537);
    rd_chk(5'h19, 16'hffff);
    rs = '{6, 7, 12, 13, 1};
    rs[4] = $urandom_range(20, 1);
    foreach (rs[i]) begin
      frame(rs[i], 1'b0);
      rd_chk(5'h16, sym_exp(rs[i]));
      rd_chk(5'h15, 16'h0001);
    end
    frame(0, 1'b0);
    rd_chk(5'h15, 16'h0000);
    frame(0, 1'b1);
    rd_chk(5'h15, 16'h0001);
    rd_chk(5'h17, 16'h0001);
    for (int c = 0; c < 16; c++) begin
      r = {13'($urandom), 3'(c)};
      wr(5'h1b, r);
      ln <= 4'($urandom);
      repeat (3) @(posedge clk);
      check(16'({act_b, lnk_b}), 16'(led_exp(3'(c), ln)));
      rd_chk(5'h1b, r);
    end
    wr(5'h1c, 16'h0040);
    repeat (3) @(posedge clk);
    check({15'h0000, pair}, 16'h0001);
    rd_chk(5'h1c, 16'h0070);
    for (int k = 0; k < 3; k++) begin
      c4 = k == 0 ? 4'h0 : k == 1 ? 4'hf : 4'($urandom_range(14, 1));
      wr(5'h1c, {12'h000, c4});
      ln <= 4'h0;
      repeat (4) @(posedge clk);
      check({15'h0000, pair}, 16'h0000);
      wr(5'h1c, {12'h008, c4});
      // Completion drops two edges after the auto bit lands
      repeat (2) @(posedge clk);
      rd_chk(5'h1c, {12'h008, c4});
      flip(t);
      flip(t);
      check(16'(t), 16'(slot_exp(c4)));
      ln <= 4'h4;
      repeat (4) @(posedge clk);
      rd_chk(5'h1c, {12'h009, c4});
      repeat (40) @(posedge clk);
      check({15'h0000, pair}, 16'h0000);
    end
    final_report();
  end
endmodule : psc_regs_tb_top
`default_nettype wire
